//--- tca_capture_array.sv
// four-channel capture array behind the special function register ports
`include "tca_defs.svh"
module tca_capture_array (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWdata,
  input wire logic sfrWrite,
  input wire logic sfrRead,
  output logic [7:0] sfrRdata,
  input wire logic [3:0] channelCapturePin,
  input wire tca_pkg::tca_internal_t internalEvents,
  input wire logic [15:0] timerCount,
  input wire logic timerRunBit,
  input wire logic timerDualSlope,
  input wire logic timerCountDown,
  input wire logic timerOverflowFlag,
  input wire logic converterOnPins,
  input wire logic externalMemoryPort,
  input wire logic arrayIrqEnable,
  output logic timerClear,
  output logic irqRequest,
  output logic [3:0] captureStrobe,
  output logic [3:0] overflowBeforeCapture
);
  localparam int CHANNELS = 4;

  logic [1:0] channelIndex;
  logic [7:0] dataHighShadow;
  logic [15:0] channelDataWord [CHANNELS];
  tca_pkg::tca_ctrl_t channelCtrl [CHANNELS];
  logic [3:0] channelFlagRegister;
  logic [3:0] pinEvent;
  logic [3:0] internalEvent;
  logic [3:0] pinAllowed;
  logic [3:0] capture;
  logic [3:0] flagSet;
  logic [3:0] clearHit;
  logic [3:0] irqTerms;
  logic wrIndex;
  logic wrHigh;
  logic wrLow;
  logic wrCtrl;
  logic wrFlags;
  tca_pkg::tca_ctrl_t selCtrl;
  logic [15:0] selData;
  logic [3:0] chanSel;
  logic [3:0] dataWriteOk;
  logic [3:0] ctrlWriteOk;
  logic [3:0] dirTake;
  logic [3:0] clearTerms;
  logic [3:0] next_channelFlagRegister;
  logic next_irqRequest;
  logic next_timerClear;
  logic [7:0] next_sfrRdata;
  tca_pkg::tca_event_t wrEvent;

  // the two-bit index and the four-bit ports serve exactly four channels
  if (CHANNELS != 4) begin : gen_bad_channels
    $error("capture array built for four channels only");
  end

  assign wrIndex = sfrWrite && sfrAddr == `TCA_ADDR_INDEX;
  assign wrHigh = sfrWrite && sfrAddr == `TCA_ADDR_HIGH;
  assign wrLow = sfrWrite && sfrAddr == `TCA_ADDR_LOW;
  assign wrCtrl = sfrWrite && sfrAddr == `TCA_ADDR_CTRL;
  assign wrFlags = sfrWrite && sfrAddr == `TCA_ADDR_FLAGS;
  assign selCtrl = channelCtrl[channelIndex];
  assign selData = channelDataWord[channelIndex];
  assign pinAllowed = externalMemoryPort ? 4'h0 : (converterOnPins ? 4'h3 : 4'hf);

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : gen_ch
      tca_channel u_ch (
        .mclk(mclk),
        .rst(rst),
        .capturePin(channelCapturePin[g]),
        .pinAllowed(pinAllowed[g]),
        .ctrl(channelCtrl[g]),
        .internalEvents(internalEvents),
        .pinEvent(pinEvent[g]),
        .internalEvent(internalEvent[g])
      );
    end
  endgenerate

  // captures need a running timer; pin events flag even when stopped
  assign capture = (pinEvent | internalEvent) & {CHANNELS{timerRunBit}};
  assign flagSet = capture | pinEvent;
  assign clearHit = wrFlags ? ~sfrWdata[3:0] : 4'h0;

  // one-hot decode of the channel index used by the control and data low writes
  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      chanSel[i] = channelIndex == 2'(i);
    end
  end

  // only the indexed channel hears a control port write
  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      ctrlWriteOk[i] = wrCtrl & chanSel[i];
    end
  end

  // capture-mode channels refuse software data writes
  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      dataWriteOk[i] = wrLow & chanSel[i] & channelCtrl[i].compareModeBit;
    end
  end

  assign wrEvent = tca_pkg::tca_event_t'(sfrWdata[`TCA_CTRL_SEL_HI:`TCA_CTRL_SEL_LO]);

  // direction is only recorded while the timer counts both ways
  assign dirTake = capture & {CHANNELS{timerDualSlope}};

  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      clearTerms[i] = capture[i] & channelCtrl[i].clearTimerOnEvent;
    end
  end

  // any channel may ask for the clear; the timer sees one pulse
  assign next_timerClear = |clearTerms;

  // a flag raised in the cycle of a software clear stays set
  assign next_channelFlagRegister = (channelFlagRegister & ~clearHit) | flagSet;

  always_ff @(posedge mclk) begin
    if (rst) begin
      channelIndex <= 2'h0;
    end else if (wrIndex) begin
      channelIndex <= sfrWdata[1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      dataHighShadow <= 8'h00;
    end else if (wrHigh) begin
      dataHighShadow <= sfrWdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < CHANNELS; i++) begin
        channelDataWord[i] <= `TCA_DATA_RESET;
      end
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        // a capture beats a software write landing in the same cycle
        if (capture[i]) begin
          channelDataWord[i] <= timerCount;
        end else if (dataWriteOk[i]) begin
          channelDataWord[i] <= {dataHighShadow, sfrWdata};
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < CHANNELS; i++) begin
        channelCtrl[i] <= `TCA_CTRL_RESET;
      end
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (ctrlWriteOk[i]) begin
          channelCtrl[i].channelIrqEnable <= sfrWdata[`TCA_CTRL_IEN];
          channelCtrl[i].clearTimerOnEvent <= sfrWdata[`TCA_CTRL_CTC];
          channelCtrl[i].compareModeBit <= sfrWdata[`TCA_CTRL_CCM];
          channelCtrl[i].eventSelect <= wrEvent;
        end
        // the spare bit never keeps what software wrote
        channelCtrl[i].unused <= 1'b0;
        // software writes never reach the direction bit
        if (dirTake[i]) begin
          channelCtrl[i].capturedDirection <= timerCountDown;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      channelFlagRegister <= `TCA_FLAGS_RESET;
    end else begin
      channelFlagRegister <= next_channelFlagRegister;
    end
  end

  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      irqTerms[i] = channelFlagRegister[i] & channelCtrl[i].channelIrqEnable;
    end
  end

  assign next_irqRequest = arrayIrqEnable & (|irqTerms);

  always_ff @(posedge mclk) begin
    if (rst) begin
      irqRequest <= 1'b0;
    end else begin
      irqRequest <= next_irqRequest;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      timerClear <= 1'b0;
    end else begin
      timerClear <= next_timerClear;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      captureStrobe <= 4'h0;
    end else begin
      captureStrobe <= capture;
    end
  end

  // keeps the overflow flag as it stood at each channel's last capture
  always_ff @(posedge mclk) begin
    if (rst) begin
      overflowBeforeCapture <= 4'h0;
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (capture[i]) begin
          overflowBeforeCapture[i] <= timerOverflowFlag;
        end
      end
    end
  end

  // unmapped addresses read as zero; no read strobe keeps the last byte
  always_comb begin
    next_sfrRdata = sfrRdata;
    if (sfrRead) begin
      case (sfrAddr)
        `TCA_ADDR_INDEX: next_sfrRdata = {6'h00, channelIndex};
        `TCA_ADDR_HIGH: next_sfrRdata = selData[15:8];
        `TCA_ADDR_LOW: next_sfrRdata = selData[7:0];
        `TCA_ADDR_CTRL: next_sfrRdata = selCtrl;
        `TCA_ADDR_FLAGS: next_sfrRdata = {4'h0, channelFlagRegister};
        default: next_sfrRdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      sfrRdata <= `TCA_RDATA_RESET;
    end else begin
      sfrRdata <= next_sfrRdata;
    end
  end
endmodule

//--- tca_defs.svh
// register offsets, field positions and reset values of the capture array
`ifndef TCA_DEFS_SVH
`define TCA_DEFS_SVH
`define TCA_ADDR_INDEX 8'hd1
`define TCA_ADDR_HIGH 8'hd2
`define TCA_ADDR_LOW 8'hd3
`define TCA_ADDR_CTRL 8'hd4
`define TCA_ADDR_FLAGS 8'hd5
`define TCA_CTRL_IEN 7
`define TCA_CTRL_DIR 6
`define TCA_CTRL_CTC 4
`define TCA_CTRL_CCM 3
`define TCA_CTRL_SEL_HI 2
`define TCA_CTRL_SEL_LO 0
`define TCA_CTRL_RESET 8'h00
`define TCA_DATA_RESET 16'h0000
`define TCA_FLAGS_RESET 4'h0
`define TCA_TIMER_CLEAR 16'h0000
`define TCA_RDATA_RESET 8'h00
`endif

//--- tca_pkg.sv
// types shared by the capture array files
package tca_pkg;
  typedef enum logic [2:0] {
    TCA_EV_OFF = 3'h0,
    TCA_EV_FALL = 3'h1,
    TCA_EV_RISE = 3'h2,
    TCA_EV_BOTH = 3'h3,
    TCA_EV_T0 = 3'h4,
    TCA_EV_T1 = 3'h5,
    TCA_EV_CMPA = 3'h6,
    TCA_EV_CMPB = 3'h7
  } tca_event_t;
  typedef struct packed {
    logic channelIrqEnable;
    logic capturedDirection;
    logic unused;
    logic clearTimerOnEvent;
    logic compareModeBit;
    tca_event_t eventSelect;
  } tca_ctrl_t;
  typedef struct packed {
    logic timer0Overflow;
    logic timer1Overflow;
    logic comparatorA;
    logic comparatorB;
  } tca_internal_t;
endpackage

//--- tca_channel.sv
// one capture channel: trigger decode and event pulse
`include "tca_defs.svh"
module tca_channel (
  input wire logic mclk,
  input wire logic rst,
  input wire logic capturePin,
  input wire logic pinAllowed,
  input wire tca_pkg::tca_ctrl_t ctrl,
  input wire tca_pkg::tca_internal_t internalEvents,
  output logic pinEvent,
  output logic internalEvent
);
  logic pinLast;
  logic rise;
  logic fall;

  always_ff @(posedge mclk) begin
    if (rst) begin
      pinLast <= 1'b0;
    end else begin
      pinLast <= capturePin;
    end
  end

  assign rise = capturePin & ~pinLast;
  assign fall = ~capturePin & pinLast;

  always_comb begin
    pinEvent = 1'b0;
    internalEvent = 1'b0;
    if (!ctrl.compareModeBit) begin
      case (ctrl.eventSelect)
        tca_pkg::TCA_EV_OFF: pinEvent = 1'b0;
        tca_pkg::TCA_EV_FALL: pinEvent = fall & pinAllowed;
        tca_pkg::TCA_EV_RISE: pinEvent = rise & pinAllowed;
        tca_pkg::TCA_EV_BOTH: pinEvent = (rise | fall) & pinAllowed;
        tca_pkg::TCA_EV_T0: internalEvent = internalEvents.timer0Overflow;
        tca_pkg::TCA_EV_T1: internalEvent = internalEvents.timer1Overflow;
        tca_pkg::TCA_EV_CMPA: internalEvent = internalEvents.comparatorA;
        tca_pkg::TCA_EV_CMPB: internalEvent = internalEvents.comparatorB;
        default: pinEvent = 1'b0;
      endcase
    end
  end
endmodule

//--- tca_cpu_model.sv
// processor model that drives the special function register bus
module tca_cpu_model (
  input wire logic mclk,
  output logic [7:0] sfrAddr,
  output logic [7:0] sfrWdata,
  output logic sfrWrite,
  output logic sfrRead,
  input wire logic [7:0] sfrRdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {sfrAddr, sfrWdata, sfrWrite, sfrRead} = 18'h0;
  // one access per call; released address and data lines show the inverse of their last value
  task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge mclk);
    #1 {sfrAddr, sfrWdata, sfrWrite, sfrRead} = {a, d, wr, !wr};
    @(posedge mclk);
    #1 {sfrAddr, sfrWdata, sfrWrite, sfrRead} = {~a, ~d, 2'h0};
    q = sfrRdata;
  endtask
endmodule

//--- tca_capture_array_chk.sv
// port assertions of the capture array
module tca_capture_array_chk (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] sfrAddr,
  input wire logic sfrRead,
  input wire logic [7:0] sfrRdata,
  input wire logic [3:0] channelCapturePin,
  input wire tca_pkg::tca_internal_t internalEvents,
  input wire logic timerOverflowFlag,
  input wire logic converterOnPins,
  input wire logic externalMemoryPort,
  input wire logic arrayIrqEnable,
  input wire logic timerClear,
  input wire logic irqRequest,
  input wire logic [3:0] captureStrobe,
  input wire logic [3:0] overflowBeforeCapture
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  property p_irq; irqRequest |-> $past(arrayIrqEnable); endproperty
  a_irq: assert property (p_irq) else $error("irq without array enable");
  property p_clr; timerClear |-> captureStrobe != 4'h0; endproperty
  a_clr: assert property (p_clr) else $error("timer clear without capture");
  property p_hold; !$past(sfrRead) |-> $stable(sfrRdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_mem; $past(externalMemoryPort) && $past(internalEvents) == 4'h0
    |-> captureStrobe == 4'h0; endproperty
  a_mem: assert property (p_mem) else $error("pin capture with memory port");
  property p_conv; $past(converterOnPins) && $past(internalEvents) == 4'h0
    |-> captureStrobe[3:2] == 2'h0; endproperty
  a_conv: assert property (p_conv) else $error("pin capture with converter");
  property p_quiet; $past(internalEvents) == 4'h0 && $past(channelCapturePin)
    == $past(channelCapturePin, 2) |-> captureStrobe == 4'h0; endproperty
  a_quiet: assert property (p_quiet) else $error("capture without event");
  property p_ovf; captureStrobe != 4'h0 |-> (overflowBeforeCapture & captureStrobe)
    == ({4{$past(timerOverflowFlag)}} & captureStrobe); endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag not kept");
  property p_unmap; $past(sfrRead) && ($past(sfrAddr) < 8'hd1 || $past(sfrAddr) > 8'hd5)
    |-> sfrRdata == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule
bind tca_capture_array tca_capture_array_chk u_tca_capture_array_chk (.mclk, .rst, .sfrAddr,
  .sfrRead, .sfrRdata, .channelCapturePin, .internalEvents, .timerOverflowFlag,
  .converterOnPins, .externalMemoryPort, .arrayIrqEnable, .timerClear, .irqRequest,
  .captureStrobe, .overflowBeforeCapture);

//--- tca_capture_array_tb.sv
// self-checking bench for the capture array
module tca_capture_array_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'h0, rst = 1'h1, tRun = 1'h1, tDual = 1'h0, tDown = 1'h0, tOvf = 1'h0;
  logic conv = 1'h0, xmem = 1'h0, aIen = 1'h0, sfrWrite, sfrRead, timerClear, irqRequest;
  logic [3:0] pins = 4'h0, strobe, ovfCap, mf = 4'h0, mdir = 4'h0;
  logic [7:0] sfrAddr, sfrWdata, sfrRdata, lo, hi, dump;
  logic [15:0] tCount = 16'h0, md[4];
  tca_pkg::tca_internal_t iev = 4'h0;
  int bad_count = 0, total_checks = 0;
  always #10 mclk = ~mclk;
  tca_cpu_model u_tca_cpu_model (.mclk, .sfrAddr, .sfrWdata, .sfrWrite, .sfrRead, .sfrRdata);
  tca_capture_array u_tca_capture_array (.mclk, .rst, .sfrAddr, .sfrWdata, .sfrWrite,
    .sfrRead, .sfrRdata, .channelCapturePin(pins), .internalEvents(iev), .timerCount(tCount),
    .timerRunBit(tRun), .timerDualSlope(tDual), .timerCountDown(tDown),
    .timerOverflowFlag(tOvf), .converterOnPins(conv), .externalMemoryPort(xmem),
    .arrayIrqEnable(aIen), .timerClear, .irqRequest, .captureStrobe(strobe),
    .overflowBeforeCapture(ovfCap));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    u_tca_cpu_model.acc(1'h1, a, d, dump);
  endtask
  task automatic r(input logic [7:0] a, output logic [7:0] q);
    u_tca_cpu_model.acc(1'h0, a, 8'h00, q);
  endtask
  task automatic chkData(input int c);
    w(8'hd1, 8'(c));
    r(8'hd3, lo);
    r(8'hd2, hi);
    chk("data", md[c], {hi, lo});
  endtask
  // one trigger on channel c; the model follows the data words, direction bits and flags
  task automatic cap(input int c, input logic [2:0] sel, input logic ctc);
    logic hit;
    w(8'hd1, 8'(c));
    pins[c] = sel == 3'h1;
    repeat (2) @(posedge mclk);
    w(8'hd4, {2'h3, 1'h0, ctc, 1'h0, sel});
    {tCount, tOvf, tDown, tDual, aIen} = 20'($urandom);
    if (sel < 3'h4) pins[c] = !pins[c];
    else iev[7 - sel] = 1'h1;
    hit = sel < 3'h4 ? !(xmem || (conv && c > 1)) : tRun;
    @(posedge mclk);
    #1 iev = 4'h0;
    if (hit && tRun) md[c] = tCount;
    if (hit && tRun && tDual) mdir[c] = tDown;
    mf[c] = mf[c] | hit;
    chk("strobe", 4'(hit && tRun) << c, strobe);
    chk("clear", hit & tRun & ctc, timerClear);
    if (hit && tRun) chk("ovf", tOvf, ovfCap[c]);
    r(8'hd4, lo);
    chk("ctrl", {1'h1, mdir[c], 1'h0, ctc, 1'h0, sel}, lo);
    chkData(c);
    r(8'hd5, lo);
    chk("flags", mf, lo);
    chk("irq", aIen & mf[c], irqRequest);
    w(8'hd5, ~(8'h01 << c));
    mf[c] = 1'h0;
    w(8'hd4, 8'h00);
    chk("irqOff", 1'h0, irqRequest);
  endtask
  initial begin
    void'($urandom(32'h7e7b4193));
    repeat (2) @(posedge mclk);
    #1 rst = 1'h0;
    for (int a = 8'hd2; a < 8'hd7; a++) begin
      r(8'(a), lo);
      chk("reset", 16'h0, lo);
    end
    $display("reset test done");
    for (int c = 0; c < 4; c++) begin
      {hi, lo} = 16'($urandom);
      w(8'hd1, 8'(c));
      w(8'hd4, 8'h08);
      if (c != 1) w(8'hd2, hi);
      w(8'hd3, lo);
      md[c] = {c != 1 ? hi : md[0][15:8], lo};
    end
    for (int c = 0; c < 4; c++) chkData(c);
    w(8'hd4, 8'h00);
    w(8'hd3, 8'h5a);
    chkData(3);
    $display("port test done");
    for (int s = 1; s < 8; s++) cap(s % 4, 3'(s), 1'($urandom));
    tRun = 1'h0;
    cap(1, 3'h2, 1'h1);
    cap(2, 3'h5, 1'h1);
    tRun = 1'h1;
    conv = 1'h1;
    cap(2, 3'h3, 1'h0);
    cap(1, 3'h1, 1'h0);
    conv = 1'h0;
    xmem = 1'h1;
    cap(0, 3'h2, 1'h0);
    cap(3, 3'h4, 1'h1);
    $display("capture test done");
    rst = 1'h1;
    repeat (2) @(posedge mclk);
    #1 rst = 1'h0;
    r(8'hd4, lo);
    chk("reset2", 16'h0, lo);
    r(8'hd5, lo);
    chk("reset2", 16'h0, lo);
    $display("second reset test done");
    end_sim();
  end
  initial begin
    #100000;
    bad_count++;
    end_sim();
  end
endmodule
